// *** ccpad_regs.sv ***
// pad pull, regulator reset status and protocol timing register group
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - host pin direction bit: 1 pull-up, 0 pull-down, only while enabled
// - phy pull enable bits 3..0 switch pulls; bits 15..4 reserved
// - phy pull direction bits 3..0 pick up or down where enabled
// - status bit 1 low-voltage reset, bit 0 power-on reset
// - reading the status register clears all flags; writes never clear
// - a cleared flag sets again on the next matching event
// - power events reset the controller like hard reset; flags seen after
// - bit duration field is bits 6..0; bit 7 and upper byte reserved
// - channel A delay compensation is 16 bits; host writes 0 to 127
// - channel B delay compensation is 16 bits; host writes 0 to 127
// - drift damping in microticks; host writes 1 to 15
// - max sync frames including own; host writes 2 to 15
// - timing registers accept writes only in configuration state
// - pull enable and direction registers reset to zero
// - setting config bit enters configuration at once; reset sets it
// - host pin enable bits 15..0 each switch the pull of one pin on or off
module ccpad_regs
  import ccpad_pkg::*;
(
  input wire logic SYS_CLK_IN, // controller clock, 125 MHz
  input wire logic RESET_IN, // external hard reset, high
  input wire logic LV_RESET_EVENT_IN, // low-voltage detect pulse
  input wire logic POR_EVENT_IN, // power-on detect pulse
  input wire logic [ADDR_W-1:0] ADDR_IN, // register byte offset
  input wire logic [DATA_W-1:0] WR_DATA_IN, // write data
  input wire logic WR_STROBE_IN, // one-cycle write
  input wire logic RD_STROBE_IN, // one-cycle read
  output logic [DATA_W-1:0] RD_DATA_OUT, // read data, cycle after strobe
  output logic CTRL_RESET_OUT, // internal reset to the controller
  output logic CONFIG_STATE_OUT, // controller in configuration
  output ccpad_timing_t TIMING_OUT, // timing parameters
  output ccpad_pull_t HOST_PULL_OUT, // host pin pulls
  output logic [PHY_PINS-1:0] PHY_PULL_UP_OUT, // phy pin pull-ups
  output logic [PHY_PINS-1:0] PHY_PULL_DOWN_OUT // phy pin pull-downs
);

  // internal reset state
  // the controller reset tree hangs off core_rst_reg; only the status flags clear on RESET_IN directly
  logic core_rst_reg;
  logic core_rst_next;

  // mode and pull registers
  // these leave every reset with known values
  ccpad_mode_t mode_reg;
  ccpad_mode_t mode_next;
  logic [HOST_PINS-1:0] host_pull_enable_reg;
  logic [HOST_PINS-1:0] host_pull_direction_reg;
  logic [PHY_PINS-1:0] phy_pull_enable_reg;
  logic [PHY_PINS-1:0] phy_pull_direction_reg;

  // regulator status flags
  // set by hardware, cleared by a host read
  logic lv_flag_reg;
  logic lv_flag_next;
  logic por_flag_reg;
  logic por_flag_next;

  // read path
  // answer comes from a flop, one cycle late
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;

  // decoded strobes
  // qualified accesses and slot lookups
  logic wr_ok;
  logic rd_ok;
  logic cfg_mode;
  logic [2:0] wr_slot;
  logic [2:0] rd_slot;
  logic status_read;
  logic [DATA_W-1:0] timing_word [NUM_TIMING];

  // write selects for registers any mode may change
  logic wr_host_en;
  logic wr_host_dir;
  logic wr_phy_en;
  logic wr_phy_dir;
  logic wr_cfg_ctrl;

  // offset compare shared by the write selects and the status read decode
  function automatic logic ofs_match(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    ofs_match = (a == ofs);
  endfunction

  // -------- internal reset --------

  // power detectors arrive as synchronous pulses;
  // a longer pulse just holds the reset longer
  // on this path a power event acts exactly like the external hard reset
  assign core_rst_next = RESET_IN | LV_RESET_EVENT_IN | POR_EVENT_IN;

  // one edge of latency buys a glitch-free level
  // registered so the reset tree sees a clean level
  always_ff @(posedge SYS_CLK_IN) begin
    core_rst_reg <= core_rst_next;
  end

  // same level goes out to the rest of the controller
  assign CTRL_RESET_OUT = core_rst_reg;

  // -------- access qualification --------

  // strobes are one cycle long, never both high;
  // the slave never stalls the host
  // the port is ignored while the controller sits in reset, so flags
  // only become visible once the internal reset has been released
  assign wr_ok = WR_STROBE_IN & ~core_rst_reg;
  assign rd_ok = RD_STROBE_IN & ~core_rst_reg;
  assign cfg_mode = (mode_reg == CCPAD_MODE_CONFIG);
  assign wr_slot = ccpad_timing_index(ADDR_IN);
  assign rd_slot = ccpad_timing_index(ADDR_IN);
  assign status_read = rd_ok & ofs_match(ADDR_IN, OFS_REG_STATUS);

  // one select per register, decoded once
  assign wr_host_en = wr_ok & ofs_match(ADDR_IN, OFS_HOST_PULL_EN);
  assign wr_host_dir = wr_ok & ofs_match(ADDR_IN, OFS_HOST_PULL_DIR);
  assign wr_phy_en = wr_ok & ofs_match(ADDR_IN, OFS_PHY_PULL_EN);
  assign wr_phy_dir = wr_ok & ofs_match(ADDR_IN, OFS_PHY_PULL_DIR);
  assign wr_cfg_ctrl = wr_ok & ofs_match(ADDR_IN, OFS_CFG_CTRL);

  // -------- operating mode --------

  // leaving configuration needs a write of zero;
  // other offsets leave the mode alone
  // next mode from the configuration control register
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      CCPAD_MODE_CONFIG: begin
        if (wr_cfg_ctrl && !WR_DATA_IN[CFG_STATE_BIT]) begin
          mode_next = CCPAD_MODE_NORMAL;
        end
      end
      CCPAD_MODE_NORMAL: begin
        // takes effect on the very next edge, no protocol handshake
        if (wr_cfg_ctrl && WR_DATA_IN[CFG_STATE_BIT]) begin
          mode_next = CCPAD_MODE_CONFIG;
        end
      end
      default: begin
        mode_next = CCPAD_MODE_CONFIG;
      end
    endcase
  end

  // internal and external resets share this path
  // hard reset leaves the controller in configuration
  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst_reg) begin
      mode_reg <= CCPAD_MODE_CONFIG;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // the mode flop drives the state output
  assign CONFIG_STATE_OUT = cfg_mode;

  // -------- host pin pull registers --------

  // enable and direction, full sixteen bits each
  // writable in any mode so pads can be retuned;
  // pad controls follow one edge later
  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst_reg) begin
      host_pull_enable_reg <= PULL_RESET[HOST_PINS-1:0];
      host_pull_direction_reg <= PULL_RESET[HOST_PINS-1:0];
    end else if (wr_ok) begin
      if (wr_host_en) begin
        host_pull_enable_reg <= WR_DATA_IN[HOST_PINS-1:0];
      end
      if (wr_host_dir) begin
        host_pull_direction_reg <= WR_DATA_IN[HOST_PINS-1:0];
      end
    end
  end

  // -------- phy pin pull registers --------

  // only the low nibble is stored; upper bits are dropped on write
  // a write never touches the other register
  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst_reg) begin
      phy_pull_enable_reg <= PULL_RESET[PHY_PINS-1:0];
      phy_pull_direction_reg <= PULL_RESET[PHY_PINS-1:0];
    end else if (wr_ok) begin
      if (wr_phy_en) begin
        phy_pull_enable_reg <= WR_DATA_IN[PHY_PINS-1:0];
      end
      if (wr_phy_dir) begin
        phy_pull_direction_reg <= WR_DATA_IN[PHY_PINS-1:0];
      end
    end
  end

  // -------- pad resolution --------

  // direction matters only where the enable bit is set
  // a disabled pin pulls neither way
  ccpad_pull_drive #(
    .N(HOST_PINS)
  ) u_host_pull (
    .clk_in(SYS_CLK_IN),
    .rst_in(core_rst_reg),
    .enable_in(host_pull_enable_reg),
    .dir_in(host_pull_direction_reg),
    .pull_up_out(HOST_PULL_OUT.up),
    .pull_down_out(HOST_PULL_OUT.down)
  );

  // same resolution for the four physical-layer pins
  ccpad_pull_drive #(
    .N(PHY_PINS)
  ) u_phy_pull (
    .clk_in(SYS_CLK_IN),
    .rst_in(core_rst_reg),
    .enable_in(phy_pull_enable_reg),
    .dir_in(phy_pull_direction_reg),
    .pull_up_out(PHY_PULL_UP_OUT),
    .pull_down_out(PHY_PULL_DOWN_OUT)
  );

  // -------- regulator reset status --------

  // the event wins over a clear in the same cycle; a read clears, a write
  // has no effect; external hard reset alone wipes the record
  // reads are refused in internal reset, so a
  // flag never clears before the host sees it
  // limitation: two events between polls look like one
  always_comb begin
    lv_flag_next = lv_flag_reg;
    por_flag_next = por_flag_reg;
    if (RESET_IN) begin
      lv_flag_next = 1'b0;
      por_flag_next = 1'b0;
    end else if (status_read) begin
      lv_flag_next = 1'b0;
      por_flag_next = 1'b0;
    end
    if (LV_RESET_EVENT_IN) begin
      lv_flag_next = 1'b1;
    end
    if (POR_EVENT_IN) begin
      por_flag_next = 1'b1;
    end
  end

  // plain flops without a reset branch
  // flags survive the internal reset that their own event causes;
  // they drive no interrupt line, software must poll them
  always_ff @(posedge SYS_CLK_IN) begin
    lv_flag_reg <= lv_flag_next;
    por_flag_reg <= por_flag_next;
  end

  // -------- protocol timing parameters --------

  // one word per parameter; write gated by configuration mode so a stray
  // write during operation cannot disturb a running schedule
  // no reset: a power event keeps the last words,
  // yet software reprograms them after each reset
  genvar k;
  generate
    for (k = 0; k < NUM_TIMING; k++) begin : g_timing
      ccpad_cfg_word #(
        .W(DATA_W),
        .MASK(ccpad_timing_mask(k))
      ) u_word (
        .clk_in(SYS_CLK_IN),
        .wr_en_in(wr_ok && cfg_mode && wr_slot == 3'(k)),
        .wr_data_in(WR_DATA_IN),
        .q_out(timing_word[k])
      );
    end
  endgenerate

  // values are passed through as stored; range limits are the host's job
  // out-of-range words are kept, not clamped
  assign TIMING_OUT.microticks_per_bit = timing_word[TI_UT_PER_BIT][6:0];
  assign TIMING_OUT.max_sync_frames = timing_word[TI_MAX_SYNC];
  assign TIMING_OUT.delay_comp_chan_a = timing_word[TI_DC_A];
  assign TIMING_OUT.delay_comp_chan_b = timing_word[TI_DC_B];
  assign TIMING_OUT.drift_damping = timing_word[TI_DRIFT];

  // -------- read path --------

  // reserved bits are zero-filled; unmapped offsets read zero
  // zero unless answering, so nothing stale lingers
  // status is taken before the clear lands
  always_comb begin
    rd_data_next = DATA_ZERO;
    if (rd_ok) begin
      if (rd_slot != TI_NONE) begin
        rd_data_next = timing_word[rd_slot];
      end else begin
        case (ADDR_IN)
          OFS_HOST_PULL_EN: begin
            rd_data_next = host_pull_enable_reg & MASK_HOST_PULL;
          end
          OFS_HOST_PULL_DIR: begin
            rd_data_next = host_pull_direction_reg & MASK_HOST_PULL;
          end
          OFS_PHY_PULL_EN: begin
            rd_data_next[PHY_PINS-1:0] = phy_pull_enable_reg;
          end
          OFS_PHY_PULL_DIR: begin
            rd_data_next[PHY_PINS-1:0] = phy_pull_direction_reg;
          end
          OFS_REG_STATUS: begin
            // value before the clear is returned
            rd_data_next[STATUS_LV_BIT] = lv_flag_reg;
            rd_data_next[STATUS_POR_BIT] = por_flag_reg;
          end
          OFS_CFG_CTRL: begin
            rd_data_next[CFG_STATE_BIT] = cfg_mode;
          end
          default: begin
            rd_data_next = DATA_ZERO;
          end
        endcase
      end
    end
  end

  // data stand for exactly the cycle after the strobe, zero otherwise
  // reset forces zero so no answer straddles it
  always_ff @(posedge SYS_CLK_IN) begin
    if (core_rst_reg) begin
      rd_data_reg <= DATA_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign RD_DATA_OUT = rd_data_reg;

endmodule
`default_nettype wire

// *** ccpad_pkg.sv ***
// shared constants, types and decode helpers for the pad, power and timing register group
package ccpad_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int HOST_PINS = 16;
  localparam int PHY_PINS = 4;

  // byte offsets on the register port
  localparam logic [7:0] OFS_HOST_PULL_EN = 8'h9e;
  localparam logic [7:0] OFS_HOST_PULL_DIR = 8'ha0;
  localparam logic [7:0] OFS_PHY_PULL_EN = 8'ha2;
  localparam logic [7:0] OFS_PHY_PULL_DIR = 8'ha4;
  localparam logic [7:0] OFS_REG_STATUS = 8'ha6;
  localparam logic [7:0] OFS_UT_PER_BIT = 8'ha8;
  localparam logic [7:0] OFS_MAX_SYNC = 8'hc2;
  localparam logic [7:0] OFS_DC_A = 8'hd0;
  localparam logic [7:0] OFS_DC_B = 8'hd2;
  localparam logic [7:0] OFS_DRIFT = 8'hde;
  localparam logic [7:0] OFS_CFG_CTRL = 8'he0;

  // implemented-bit masks; everything else is reserved and reads zero
  localparam logic [15:0] MASK_HOST_PULL = 16'hffff;
  localparam logic [15:0] MASK_PHY_PULL = 16'h000f;
  localparam logic [15:0] MASK_UT_PER_BIT = 16'h007f;
  localparam logic [15:0] MASK_FULL = 16'hffff;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  // field positions and reset values
  localparam int STATUS_POR_BIT = 0;
  localparam int STATUS_LV_BIT = 1;
  localparam int CFG_STATE_BIT = 0;
  localparam logic [15:0] PULL_RESET = 16'h0000;

  // timing parameter word slots
  localparam int NUM_TIMING = 5;
  localparam logic [2:0] TI_UT_PER_BIT = 3'h0;
  localparam logic [2:0] TI_MAX_SYNC = 3'h1;
  localparam logic [2:0] TI_DC_A = 3'h2;
  localparam logic [2:0] TI_DC_B = 3'h3;
  localparam logic [2:0] TI_DRIFT = 3'h4;
  localparam logic [2:0] TI_NONE = 3'h7;

  // controller operating mode; reset lands in configuration
  typedef enum logic [0:0] {
    CCPAD_MODE_NORMAL = 1'b0,
    CCPAD_MODE_CONFIG = 1'b1
  } ccpad_mode_t;

  // timing parameters handed to the protocol engine
  typedef struct packed {
    logic [6:0] microticks_per_bit;
    logic [15:0] max_sync_frames;
    logic [15:0] delay_comp_chan_a;
    logic [15:0] delay_comp_chan_b;
    logic [15:0] drift_damping;
  } ccpad_timing_t;

  // resolved pull request for a group of pins
  typedef struct packed {
    logic [HOST_PINS-1:0] up;
    logic [HOST_PINS-1:0] down;
  } ccpad_pull_t;

  // map an offset to its timing slot, used by write and read paths
  function automatic logic [2:0] ccpad_timing_index(input logic [7:0] addr);
    case (addr)
      OFS_UT_PER_BIT: ccpad_timing_index = TI_UT_PER_BIT;
      OFS_MAX_SYNC: ccpad_timing_index = TI_MAX_SYNC;
      OFS_DC_A: ccpad_timing_index = TI_DC_A;
      OFS_DC_B: ccpad_timing_index = TI_DC_B;
      OFS_DRIFT: ccpad_timing_index = TI_DRIFT;
      default: ccpad_timing_index = TI_NONE;
    endcase
  endfunction

  // implemented bits of each timing slot
  function automatic logic [15:0] ccpad_timing_mask(input int idx);
    ccpad_timing_mask = (idx == int'(TI_UT_PER_BIT)) ? MASK_UT_PER_BIT : MASK_FULL;
  endfunction

endpackage

// *** ccpad_cfg_word.sv ***
// one configuration-only parameter word without reset
`timescale 1ns/10ps
`default_nettype none
module ccpad_cfg_word #(
  parameter int W = 16,
  parameter logic [15:0] MASK = 16'hffff
) (
  input wire logic clk_in, // controller clock
  input wire logic wr_en_in, // qualified write
  input wire logic [W-1:0] wr_data_in, // host data
  output logic [W-1:0] q_out // stored value
);

  logic [W-1:0] q_reg;

  // no reset on purpose: contents are undefined until the host programs them
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      q_reg <= wr_data_in & MASK[W-1:0];
    end
  end

  assign q_out = q_reg;

endmodule
`default_nettype wire

// *** ccpad_pull_drive.sv ***
// per-pin pull resistor resolution from enable and direction bits
`timescale 1ns/10ps
`default_nettype none
module ccpad_pull_drive #(
  parameter int N = 16
) (
  input wire logic clk_in, // controller clock
  input wire logic rst_in, // synchronous reset, high
  input wire logic [N-1:0] enable_in, // pull on per pin
  input wire logic [N-1:0] dir_in, // 1 up, 0 down
  output logic [N-1:0] pull_up_out, // pull-up active
  output logic [N-1:0] pull_down_out // pull-down active
);

  logic [N-1:0] up_reg;
  logic [N-1:0] down_reg;

  // registered so pad controls never glitch while the host rewrites a bit
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          up_reg[i] <= 1'b0;
          down_reg[i] <= 1'b0;
        end else begin
          up_reg[i] <= enable_in[i] & dir_in[i];
          down_reg[i] <= enable_in[i] & ~dir_in[i];
        end
      end
    end
  endgenerate

  assign pull_up_out = up_reg;
  assign pull_down_out = down_reg;

endmodule
`default_nettype wire

// *** ccpad_regs_sva.sv ***
// port assertions for the pad, power and timing register group
`timescale 1ns/10ps
`default_nettype none
module ccpad_regs_sva
  import ccpad_pkg::*;
(
  input wire logic SYS_CLK_IN, // clock
  input wire logic RESET_IN, // hard reset
  input wire logic LV_RESET_EVENT_IN, // low-voltage event
  input wire logic POR_EVENT_IN, // power-on event
  input wire logic [ADDR_W-1:0] ADDR_IN, // offset
  input wire logic [DATA_W-1:0] WR_DATA_IN, // write data
  input wire logic WR_STROBE_IN, // write
  input wire logic RD_STROBE_IN, // read
  input wire logic [DATA_W-1:0] RD_DATA_OUT, // read data
  input wire logic CTRL_RESET_OUT, // internal reset
  input wire logic CONFIG_STATE_OUT, // config state
  input wire ccpad_timing_t TIMING_OUT, // timing
  input wire ccpad_pull_t HOST_PULL_OUT, // host pulls
  input wire logic [PHY_PINS-1:0] PHY_PULL_UP_OUT, // phy ups
  input wire logic [PHY_PINS-1:0] PHY_PULL_DOWN_OUT // phy downs
);
  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  // an access counts only while the internal reset is low
  wire logic wr_ok = WR_STROBE_IN && !CTRL_RESET_OUT;
  wire logic st_rd = RD_STROBE_IN && ADDR_IN == OFS_REG_STATUS && !CTRL_RESET_OUT;
  wire logic no_evt = !LV_RESET_EVENT_IN && !POR_EVENT_IN;
  a_rd_idle_zero: assert property (
    !$past(RD_STROBE_IN) |-> RD_DATA_OUT == DATA_ZERO)
    else $error("read data not zero outside answer");
  a_status_rsv_zero: assert property (
    $past(RD_STROBE_IN && ADDR_IN == OFS_REG_STATUS) |-> RD_DATA_OUT[15:2] == 14'h0000)
    else $error("status reserved bits set");
  a_status_read_clear: assert property (
    (st_rd && no_evt) ##1 (st_rd && no_evt) |=> RD_DATA_OUT == DATA_ZERO)
    else $error("status not cleared by read");
  a_event_hard_reset: assert property (
    !no_evt |=> CTRL_RESET_OUT ##1 CONFIG_STATE_OUT)
    else $error("power event did not reset controller");
  a_hard_reset_end: assert property (
    $fell(RESET_IN) && no_evt |-> CTRL_RESET_OUT && CONFIG_STATE_OUT ##1 !CTRL_RESET_OUT)
    else $error("internal reset release wrong");
  a_pulls_after_reset: assert property (
    $fell(CTRL_RESET_OUT) |-> ##1 (HOST_PULL_OUT == 32'h00000000
      && PHY_PULL_UP_OUT == 4'h0 && PHY_PULL_DOWN_OUT == 4'h0))
    else $error("pulls not cleared by reset");
  a_config_write: assert property (
    wr_ok && ADDR_IN == OFS_CFG_CTRL |=> CONFIG_STATE_OUT == $past(WR_DATA_IN[0]))
    else $error("config bit write lost");
  a_dcb_write_taken: assert property (
    wr_ok && ADDR_IN == OFS_DC_B && CONFIG_STATE_OUT
      |=> TIMING_OUT.delay_comp_chan_b == $past(WR_DATA_IN))
    else $error("channel b compensation write lost");
  a_dca_write_locked: assert property (
    wr_ok && ADDR_IN == OFS_DC_A && !CONFIG_STATE_OUT |=> $stable(TIMING_OUT.delay_comp_chan_a))
    else $error("channel a compensation changed outside config");
  a_phy_enable_map: assert property (
    (wr_ok && ADDR_IN == OFS_PHY_PULL_EN) ##1 (!WR_STROBE_IN && !CTRL_RESET_OUT)
      |=> (PHY_PULL_UP_OUT | PHY_PULL_DOWN_OUT) == $past(WR_DATA_IN[3:0], 2))
    else $error("phy pulls do not follow enable");
  a_host_dir_map: assert property (
    (wr_ok && ADDR_IN == OFS_HOST_PULL_DIR) ##1 (!WR_STROBE_IN && !CTRL_RESET_OUT)
      |=> HOST_PULL_OUT.up == ($past(WR_DATA_IN, 2) & (HOST_PULL_OUT.up | HOST_PULL_OUT.down)))
    else $error("host pull-ups do not follow direction");
endmodule
`default_nettype wire

// *** ccpad_host.sv ***
// host side register port master
`timescale 1ns/10ps
`default_nettype none
module ccpad_host
  import ccpad_pkg::*;
(
  input wire logic clk_in, // controller clock
  output logic [ADDR_W-1:0] addr_out, // byte offset
  output logic [DATA_W-1:0] wr_data_out, // write data
  output logic wr_strobe_out, // one-cycle write
  output logic rd_strobe_out, // one-cycle read
  input wire logic [DATA_W-1:0] rd_data_in // read data
);
  // idle bus from time zero
  initial begin
    addr_out = 8'h00;
    wr_data_out = 16'h0000;
    wr_strobe_out = 1'b0;
    rd_strobe_out = 1'b0;
  end
  // one write; data is inverted afterwards so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_strobe_out <= 1'b1;
    @(posedge clk_in);
    wr_strobe_out <= 1'b0;
    wr_data_out <= ~d;
    #1;
  endtask
  // two back-to-back reads; status is polled since no interrupt exists
  task automatic rd(input logic [7:0] a, output logic [15:0] d1, output logic [15:0] d2);
    @(posedge clk_in);
    addr_out <= a;
    rd_strobe_out <= 1'b1;
    @(posedge clk_in);
    #1 d1 = rd_data_in;
    @(posedge clk_in);
    rd_strobe_out <= 1'b0;
    #1 d2 = rd_data_in;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the pad, power and timing register group
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ccpad_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic lv_evt = 1'b0;
  logic por_evt = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, d1, d2, hen, hdir, pen, pdir, v;
  logic wr_stb, rd_stb, ctrl_rst, cfg_state;
  ccpad_timing_t timing;
  ccpad_pull_t host_pull;
  logic [PHY_PINS-1:0] phy_up, phy_dn;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] tval [5];
  logic [7:0] tofs [5] = '{OFS_UT_PER_BIT, OFS_MAX_SYNC, OFS_DC_A, OFS_DC_B, OFS_DRIFT};
  logic [15:0] tlo [5] = '{16'hff80, 16'h0002, 16'h0000, 16'h0000, 16'h0001};
  logic [15:0] thi [5] = '{16'hffff, 16'h000f, 16'h007f, 16'h007f, 16'h000f};
  always #4 sys_clk = ~sys_clk;
  ccpad_regs i_ccpad_regs (.SYS_CLK_IN(sys_clk), .RESET_IN(reset), .LV_RESET_EVENT_IN(lv_evt),
    .POR_EVENT_IN(por_evt), .ADDR_IN(addr), .WR_DATA_IN(wr_data), .WR_STROBE_IN(wr_stb),
    .RD_STROBE_IN(rd_stb), .RD_DATA_OUT(rd_data), .CTRL_RESET_OUT(ctrl_rst),
    .CONFIG_STATE_OUT(cfg_state), .TIMING_OUT(timing), .HOST_PULL_OUT(host_pull),
    .PHY_PULL_UP_OUT(phy_up), .PHY_PULL_DOWN_OUT(phy_dn));
  ccpad_host i_ccpad_host (.clk_in(sys_clk), .addr_out(addr), .wr_data_out(wr_data),
    .wr_strobe_out(wr_stb), .rd_strobe_out(rd_stb), .rd_data_in(rd_data));
  // implemented bits of a timing slot
  function automatic logic [15:0] tmask(input int s);
    return (s == 0) ? 16'h007f : 16'hffff;
  endfunction
  // one timing slot out of the parameter bundle
  function automatic logic [15:0] tfield(input ccpad_timing_t t, input int s);
    case (s)
      0: return {9'h000, t.microticks_per_bit};
      1: return t.max_sync_frames;
      2: return t.delay_comp_chan_a;
      3: return t.delay_comp_chan_b;
      default: return t.drift_damping;
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr_pulls();
    i_ccpad_host.wr(OFS_HOST_PULL_EN, hen);
    i_ccpad_host.wr(OFS_HOST_PULL_DIR, hdir);
    i_ccpad_host.wr(OFS_PHY_PULL_EN, pen);
    i_ccpad_host.wr(OFS_PHY_PULL_DIR, pdir);
  endtask
  // readback and pin outputs; the reads also give the two-edge output delay time to pass
  task automatic check_pulls();
    i_ccpad_host.rd(OFS_HOST_PULL_EN, d1, d2);
    check("host_pin_pull_enable", d1, hen);
    i_ccpad_host.rd(OFS_HOST_PULL_DIR, d1, d2);
    check("host_pin_pull_direction", d1, hdir);
    i_ccpad_host.rd(OFS_PHY_PULL_EN, d1, d2);
    check("phy_pin_pull_enable", d1, pen & MASK_PHY_PULL);
    i_ccpad_host.rd(OFS_PHY_PULL_DIR, d1, d2);
    check("phy_pin_pull_direction", d1, pdir & MASK_PHY_PULL);
    check("host_pull_up", host_pull.up, hen & hdir);
    check("host_pull_down", host_pull.down, hen & ~hdir);
    check("phy_pull_up", {12'h000, phy_up}, pen & pdir & MASK_PHY_PULL);
    check("phy_pull_down", {12'h000, phy_dn}, pen & ~pdir & MASK_PHY_PULL);
  endtask
  // hang guard, far above the expected run of a few hundred cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    v = $urandom(37012);
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    {hen, hdir, pen, pdir} = 64'h0;
    check_pulls();
    i_ccpad_host.rd(OFS_CFG_CTRL, d1, d2);
    check("config_bit", d1, 16'h0001);
    i_ccpad_host.rd(OFS_REG_STATUS, d1, d2);
    check("status_after_reset", d1, 16'h0000);
    i_ccpad_host.rd(8'h40, d1, d2);
    check("unmapped_read", d1, 16'h0000);
    // random pull settings, reserved phy bits written with ones too
    for (int i = 0; i < 12; i++) begin
      {hen, hdir, pen, pdir} = {$urandom, $urandom};
      wr_pulls();
      check_pulls();
    end
    // timing words at the low bound, the high bound, then random in range
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 5; s++) begin
        v = (p == 0) ? tlo[s] : (p == 1) ? thi[s] : tlo[s] + 16'($urandom % (thi[s] - tlo[s] + 1));
        tval[s] = v;
        i_ccpad_host.wr(tofs[s], v);
        check("timing_out", tfield(timing, s), v & tmask(s));
        i_ccpad_host.rd(tofs[s], d1, d2);
        check("timing_readback", d1, v & tmask(s));
      end
    end
    // all timing words are valid before leaving configuration
    i_ccpad_host.wr(OFS_CFG_CTRL, 16'h0000);
    check("config_left", {15'h0000, cfg_state}, 16'h0000);
    for (int s = 0; s < 5; s++) begin
      i_ccpad_host.wr(tofs[s], ~tval[s]);
      i_ccpad_host.rd(tofs[s], d1, d2);
      check("timing_locked", d1, tval[s] & tmask(s));
      check("timing_out_locked", tfield(timing, s), tval[s] & tmask(s));
    end
    i_ccpad_host.wr(OFS_CFG_CTRL, 16'h0001);
    check("config_entered", {15'h0000, cfg_state}, 16'h0001);
    // each power event kind, with pulls on and normal mode beforehand
    for (int k = 1; k < 4; k++) begin
      i_ccpad_host.wr(OFS_CFG_CTRL, 16'h0000);
      {hen, hdir, pen, pdir} = {16'hffff, 16'($urandom), 16'h000f, 16'($urandom)};
      wr_pulls();
      @(posedge sys_clk);
      lv_evt <= k[1];
      por_evt <= k[0];
      @(posedge sys_clk);
      lv_evt <= 1'b0;
      por_evt <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      check("config_after_event", {15'h0000, cfg_state}, 16'h0001);
      {hen, hdir, pen, pdir} = 64'h0;
      check_pulls();
      i_ccpad_host.wr(OFS_REG_STATUS, 16'hffff);
      i_ccpad_host.rd(OFS_REG_STATUS, d1, d2);
      check("status_flags", d1, 16'(k));
      check("status_cleared", d2, 16'h0000);
    end
    // mid-run hard reset wipes a fresh flag and restores configuration
    i_ccpad_host.wr(OFS_CFG_CTRL, 16'h0000);
    @(posedge sys_clk);
    por_evt <= 1'b1;
    @(posedge sys_clk);
    por_evt <= 1'b0;
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("config_after_hard_reset", {15'h0000, cfg_state}, 16'h0001);
    i_ccpad_host.rd(OFS_REG_STATUS, d1, d2);
    check("status_after_hard_reset", d1, 16'h0000);
    print_verdict();
  end
endmodule
bind ccpad_regs ccpad_regs_sva i_ccpad_regs_sva (.SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN),
  .LV_RESET_EVENT_IN(LV_RESET_EVENT_IN), .POR_EVENT_IN(POR_EVENT_IN), .ADDR_IN(ADDR_IN),
  .WR_DATA_IN(WR_DATA_IN), .WR_STROBE_IN(WR_STROBE_IN), .RD_STROBE_IN(RD_STROBE_IN),
  .RD_DATA_OUT(RD_DATA_OUT), .CTRL_RESET_OUT(CTRL_RESET_OUT),
  .CONFIG_STATE_OUT(CONFIG_STATE_OUT), .TIMING_OUT(TIMING_OUT), .HOST_PULL_OUT(HOST_PULL_OUT),
  .PHY_PULL_UP_OUT(PHY_PULL_UP_OUT), .PHY_PULL_DOWN_OUT(PHY_PULL_DOWN_OUT));
`default_nettype wire
